// ==== hdl/rivm_pkg.sv ====
// constants, table and helpers for the reset and interrupt vector map
package rivm_pkg;

    localparam int NUM_IRQ = 25;
    localparam int ADDR_W  = 12;
    localparam int IDX_W   = 5;

    localparam logic [ADDR_W-1:0] ADDR_ZERO      = 12'h000;
    localparam logic [ADDR_W-1:0] VEC_RESET      = 12'h000;
    localparam logic [ADDR_W-1:0] VEC_TABLE_BASE = 12'h001;
    // boot flash start is set by the boot size fuses outside this block
    localparam logic [ADDR_W-1:0] DEF_BOOT_START = 12'hC00;

    // fuse value 0 means programmed
    localparam logic FUSE_PROGRAMMED = 1'b0;

    localparam logic [1:0] SETTLE_DONE = 2'h2;

    // source index, lowest index has the highest priority
    localparam logic [IDX_W-1:0] SRC_EXTERNAL_IRQ_ZERO    = 5'h00;
    localparam logic [IDX_W-1:0] SRC_EXTERNAL_IRQ_ONE     = 5'h01;
    localparam logic [IDX_W-1:0] SRC_PIN_CHANGE_IRQ_ZERO  = 5'h02;
    localparam logic [IDX_W-1:0] SRC_WATCHDOG_TIMEOUT_IRQ = 5'h05;
    localparam logic [IDX_W-1:0] SRC_TIMER2_CMPA          = 5'h06;
    localparam logic [IDX_W-1:0] SRC_TIMER2_OVF           = 5'h08;
    localparam logic [IDX_W-1:0] SRC_TIMER1_CAPT          = 5'h09;
    localparam logic [IDX_W-1:0] SRC_TIMER1_OVF           = 5'h0C;
    localparam logic [IDX_W-1:0] SRC_TIMER0_CMPA          = 5'h0D;
    localparam logic [IDX_W-1:0] SRC_TIMER0_OVF           = 5'h0F;
    localparam logic [IDX_W-1:0] SRC_SPI_DONE             = 5'h10;
    localparam logic [IDX_W-1:0] SRC_UART_RX_DONE         = 5'h11;
    localparam logic [IDX_W-1:0] SRC_UART_TX_DONE         = 5'h13;
    localparam logic [IDX_W-1:0] SRC_ADC_DONE             = 5'h14;
    localparam logic [IDX_W-1:0] SRC_PROGRAM_STORE_READY  = 5'h18;

    localparam logic [ADDR_W-1:0] VEC_TABLE [NUM_IRQ] = '{
        12'h001, 12'h002,
        12'h003, 12'h004, 12'h005, 12'h006,
        12'h007, 12'h008, 12'h009,
        12'h00A, 12'h00B, 12'h00C, 12'h00D,
        12'h00E, 12'h00F, 12'h010,
        12'h011,
        12'h012, 12'h013, 12'h014,
        12'h015, 12'h016, 12'h017, 12'h018, 12'h019
    };

    typedef enum logic [1:0] {
        ST_SYNC  = 2'b00,
        ST_RESET = 2'b01,
        ST_IDLE  = 2'b10,
        ST_ISSUE = 2'b11
    } rivm_state_t;

    // table entry moved by the boot flash start when vectors are relocated
    function automatic logic [ADDR_W-1:0] vec_addr(
        input logic [IDX_W-1:0]  idx,
        input logic              vector_select_bit,
        input logic [ADDR_W-1:0] boot
    );
        logic [ADDR_W-1:0] off;
        off      = vector_select_bit ? boot : ADDR_ZERO;
        vec_addr = off + VEC_TABLE[idx];
    endfunction : vec_addr

    function automatic logic [NUM_IRQ-1:0] one_hot(input logic [IDX_W-1:0] idx);
        logic [NUM_IRQ-1:0] v;
        v      = '0;
        v[idx] = 1'b1;
        one_hot = v;
    endfunction : one_hot

endpackage : rivm_pkg

// ==== hdl/rivm_pick_if.sv ====
// carrier between the vector map and its priority picker
`timescale 1ns/10ps
interface rivm_pick_if;
    logic [rivm_pkg::NUM_IRQ-1:0] pending;
    logic                         valid;
    logic [rivm_pkg::IDX_W-1:0]   idx;

    modport req  (output pending, input  valid, input idx);
    modport pick (input  pending, output valid, output idx);
endinterface : rivm_pick_if

// ==== hdl/rivm_prio_pick.sv ====
// registered lowest-index priority picker
`timescale 1ns/10ps
module rivm_prio_pick (
    input  wire logic   mclk_i,
    input  wire logic   nrst_i,
    rivm_pick_if.pick   pk
);

    typedef struct packed {
        logic                       valid;
        logic [rivm_pkg::IDX_W-1:0] idx;
    } rivm_pick_t;

    rivm_pick_t pick_r;
    rivm_pick_t pick_nxt;

    always_comb begin
        pick_nxt = '0;
        // scan downward so the lowest pending index wins
        for (int i = rivm_pkg::NUM_IRQ - 1; i >= 0; i--) begin
            if (pk.pending[i]) begin
                pick_nxt.valid = 1'b1;
                pick_nxt.idx   = rivm_pkg::IDX_W'(i);
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pick_r <= '0;
        end else begin
            pick_r <= pick_nxt;
        end
    end

    assign pk.valid = pick_r.valid;
    assign pk.idx   = pick_r.idx;

    a_pick_lowest: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        pk.valid |-> ($past(pk.pending) & (rivm_pkg::one_hot(pk.idx) - 25'h1)) == '0
            && ($past(pk.pending) & rivm_pkg::one_hot(pk.idx)) != '0)
        else $error("picker did not choose the lowest pending source");

    a_pick_none: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ##1 ($past(pk.pending) == '0) |-> !pk.valid)
        else $error("picker valid without any pending source");

endmodule : rivm_prio_pick

// ==== hdl/rivm_vector_map.sv ====
// reset and interrupt vector map between peripheral requests and the core
`timescale 1ns/10ps
module rivm_vector_map #(
    parameter logic [rivm_pkg::ADDR_W-1:0] BOOT_START = rivm_pkg::DEF_BOOT_START
) (
    input  wire logic                          mclk_i,
    input  wire logic                          nrst_i,
    input  wire logic [rivm_pkg::NUM_IRQ-1:0]  irq_req_i,
    input  wire logic [rivm_pkg::NUM_IRQ-1:0]  irq_en_i,
    input  wire logic                          gie_i,
    input  wire logic                          boot_reset_fuse_i,
    input  wire logic                          vector_select_bit_i,
    input  wire logic                          vec_ack_i,
    output logic                               vec_valid_o,
    output logic [rivm_pkg::ADDR_W-1:0]        vec_addr_o,
    output logic                               vec_is_reset_o,
    output logic [rivm_pkg::IDX_W-1:0]         vec_src_o,
    output logic [rivm_pkg::NUM_IRQ-1:0]       irq_ack_o
);

    typedef struct packed {
        rivm_pkg::rivm_state_t        st;
        logic [1:0]                   settle;
        logic                         fuse_s1;
        logic                         fuse_s2;
        logic                         fuse_prog;
        logic                         vector_select_bit;
        logic                         is_reset;
        logic [rivm_pkg::IDX_W-1:0]   src;
        logic [rivm_pkg::ADDR_W-1:0]  addr;
    } rivm_map_t;

    rivm_map_t map_r;
    rivm_map_t map_nxt;

    logic [rivm_pkg::NUM_IRQ-1:0] pending;
    logic                         take;

    rivm_pick_if pick_bus ();

    // a disabled source never reaches the picker
    assign pending          = irq_req_i & irq_en_i;
    assign pick_bus.pending = pending;

    rivm_prio_pick u_pick (
        .mclk_i (mclk_i),
        .nrst_i (nrst_i),
        .pk     (pick_bus)
    );

    // the pick is one cycle old, so re-check the source is still pending
    assign take = gie_i && pick_bus.valid && pending[pick_bus.idx];

    always_comb begin
        map_nxt = map_r;
        // the fuse is a level from outside this clock, two flops first
        map_nxt.fuse_s1 = boot_reset_fuse_i;
        map_nxt.fuse_s2 = map_r.fuse_s1;
        unique case (map_r.st)
            rivm_pkg::ST_SYNC: begin
                if (map_r.settle == rivm_pkg::SETTLE_DONE) begin
                    map_nxt.fuse_prog = (map_r.fuse_s2 == rivm_pkg::FUSE_PROGRAMMED);
                    map_nxt.is_reset  = 1'b1;
                    map_nxt.src       = '0;
                    if (map_r.fuse_s2 == rivm_pkg::FUSE_PROGRAMMED) begin
                        map_nxt.addr = BOOT_START;
                    end else begin
                        map_nxt.addr = rivm_pkg::VEC_RESET;
                    end
                    map_nxt.st = rivm_pkg::ST_RESET;
                end else begin
                    map_nxt.settle = map_r.settle + 2'h1;
                end
            end
            rivm_pkg::ST_RESET: begin
                if (vec_ack_i) begin
                    map_nxt.is_reset = 1'b0;
                    map_nxt.st       = rivm_pkg::ST_IDLE;
                end
            end
            rivm_pkg::ST_IDLE: begin
                if (take) begin
                    map_nxt.src   = pick_bus.idx;
                    map_nxt.vector_select_bit = vector_select_bit_i;
                    // offset depends only on vector select, never on the fuse
                    map_nxt.addr  = rivm_pkg::vec_addr(pick_bus.idx, vector_select_bit_i,
                                                       BOOT_START);
                    map_nxt.st    = rivm_pkg::ST_ISSUE;
                end
            end
            rivm_pkg::ST_ISSUE: begin
                if (vec_ack_i) begin
                    map_nxt.st = rivm_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            map_r <= '0;
        end else begin
            map_r <= map_nxt;
        end
    end

    assign vec_valid_o    = (map_r.st == rivm_pkg::ST_RESET) || (map_r.st == rivm_pkg::ST_ISSUE);
    assign vec_addr_o     = map_r.addr;
    assign vec_is_reset_o = map_r.is_reset;
    assign vec_src_o      = map_r.src;
    // combinational so the peripheral clears its flag at the same edge
    assign irq_ack_o      = (map_r.st == rivm_pkg::ST_ISSUE && vec_ack_i)
                          ? rivm_pkg::one_hot(map_r.src) : '0;

    // helpers for the checks below
    logic                        irq_out;
    logic [rivm_pkg::ADDR_W-1:0] rel_addr;
    logic [rivm_pkg::ADDR_W-1:0] exp_rel;
    assign irq_out  = vec_valid_o && !vec_is_reset_o;
    assign rel_addr = vec_addr_o - (map_r.vector_select_bit ? BOOT_START : rivm_pkg::ADDR_ZERO);
    assign exp_rel  = rivm_pkg::VEC_TABLE_BASE + rivm_pkg::ADDR_W'(vec_src_o);

    a_reset_at_zero: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (vec_valid_o && vec_is_reset_o && !map_r.fuse_prog) |-> vec_addr_o == rivm_pkg::VEC_RESET)
        else $error("unprogrammed fuse reset vector not at zero");

    a_reset_to_boot: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (vec_valid_o && vec_is_reset_o && map_r.fuse_prog) |-> vec_addr_o == BOOT_START)
        else $error("programmed fuse reset vector not at boot start");

    a_fuse_sense: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        $rose(vec_is_reset_o) |-> map_r.fuse_prog == ($past(map_r.fuse_s2) == 1'b0))
        else $error("fuse polarity taken wrongly");

    a_reset_first: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        !$past(nrst_i) |-> ##3 (vec_valid_o && vec_is_reset_o))
        else $error("reset vector not presented after reset");

    a_ext_addr: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (irq_out && vec_src_o <= rivm_pkg::SRC_EXTERNAL_IRQ_ONE) |-> rel_addr == exp_rel)
        else $error("external request vector misplaced");

    a_pin_wdt_addr: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (irq_out && vec_src_o >= rivm_pkg::SRC_PIN_CHANGE_IRQ_ZERO
                 && vec_src_o <= rivm_pkg::SRC_WATCHDOG_TIMEOUT_IRQ) |-> rel_addr == exp_rel)
        else $error("pin change or watchdog vector misplaced");

    a_tmr2_addr: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (irq_out && vec_src_o >= rivm_pkg::SRC_TIMER2_CMPA
                 && vec_src_o <= rivm_pkg::SRC_TIMER2_OVF) |-> rel_addr == exp_rel)
        else $error("second 8-bit timer vector misplaced");

    a_tmr1_addr: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (irq_out && vec_src_o >= rivm_pkg::SRC_TIMER1_CAPT
                 && vec_src_o <= rivm_pkg::SRC_TIMER1_OVF) |-> rel_addr == exp_rel)
        else $error("16-bit timer vector misplaced");

    a_tmr0_addr: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (irq_out && vec_src_o >= rivm_pkg::SRC_TIMER0_CMPA
                 && vec_src_o <= rivm_pkg::SRC_TIMER0_OVF) |-> rel_addr == exp_rel)
        else $error("first 8-bit timer vector misplaced");

    a_spi_addr: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (irq_out && vec_src_o == rivm_pkg::SRC_SPI_DONE) |-> rel_addr == exp_rel)
        else $error("serial peripheral vector misplaced");

    a_uart_addr: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (irq_out && vec_src_o >= rivm_pkg::SRC_UART_RX_DONE
                 && vec_src_o <= rivm_pkg::SRC_UART_TX_DONE) |-> rel_addr == exp_rel)
        else $error("serial port vector misplaced");

    a_misc_addr: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (irq_out && vec_src_o >= rivm_pkg::SRC_ADC_DONE
                 && vec_src_o <= rivm_pkg::SRC_PROGRAM_STORE_READY) |-> rel_addr == exp_rel)
        else $error("remaining vector misplaced");

    a_relocate: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        $rose(irq_out) |-> map_r.vector_select_bit == $past(vector_select_bit_i)
            && vec_addr_o == rivm_pkg::VEC_TABLE[vec_src_o]
                + ($past(vector_select_bit_i) ? BOOT_START : rivm_pkg::ADDR_ZERO))
        else $error("vector select offset not applied");

    a_table_start: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (irq_out && vec_src_o == rivm_pkg::SRC_EXTERNAL_IRQ_ZERO)
        |-> vec_addr_o == (map_r.vector_select_bit ? BOOT_START + rivm_pkg::VEC_TABLE_BASE
                                       : rivm_pkg::VEC_TABLE_BASE))
        else $error("interrupt table start wrong");

    a_only_enabled: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        $rose(irq_out) |-> $past(gie_i)
            && ($past(pending) & rivm_pkg::one_hot(vec_src_o)) != '0)
        else $error("vector issued for a source not taken");

    a_ack_match: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (irq_ack_o != '0) |-> irq_out && vec_ack_i && $onehot(irq_ack_o)
            && irq_ack_o[vec_src_o])
        else $error("acknowledge does not match issued source");

    a_lowest_wins: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        $rose(irq_out) |-> ($past(pending, 2) & $past(pending)
            & (rivm_pkg::one_hot(vec_src_o) - 25'h1)) == '0)
        else $error("a lower pending source was passed over");

    a_hold_vec: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (vec_valid_o && !vec_ack_i) |=> vec_valid_o && $stable(vec_addr_o) && $stable(vec_src_o))
        else $error("vector changed before acknowledge");

    // ordering, hold and liveness seen from the core side
    a_reset_src_zero: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (vec_valid_o && vec_is_reset_o) |-> vec_src_o == '0 && irq_ack_o == '0)
        else $error("reset vector carries a source or an acknowledge");

    a_sync_len: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (map_r.st == rivm_pkg::ST_SYNC && map_r.settle == rivm_pkg::SETTLE_DONE)
        |=> vec_valid_o && vec_is_reset_o)
        else $error("reset vector late after fuse settle");

    a_sync_no_irq: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (map_r.st == rivm_pkg::ST_SYNC) |=> !irq_out)
        else $error("interrupt vector before the reset vector");

    a_reset_once: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (vec_valid_o && vec_is_reset_o && vec_ack_i) |=> !vec_valid_o && !vec_is_reset_o)
        else $error("reset vector presented again after acknowledge");

    a_gap_after_ack: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (irq_out && vec_ack_i) |=> !vec_valid_o)
        else $error("no idle cycle after an acknowledged vector");

    a_ack_pulse: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (irq_ack_o != '0) |=> irq_ack_o == '0)
        else $error("source acknowledge longer than one cycle");

    a_gie_off_quiet: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (!gie_i && map_r.st == rivm_pkg::ST_IDLE) |=> !vec_valid_o)
        else $error("vector issued while interrupts are off");

    a_disabled_quiet: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (pending == '0 && map_r.st == rivm_pkg::ST_IDLE) |=> !vec_valid_o)
        else $error("vector issued with no enabled request");

    // a steady enabled request must be served, so a stuck picker cannot hide
    a_issue_timely: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (map_r.st == rivm_pkg::ST_IDLE && gie_i && pending != '0)
        ##1 (map_r.st == rivm_pkg::ST_IDLE && gie_i && $stable(pending)) |=> irq_out)
        else $error("steady enabled request not served");

    a_issue_latency: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (take && map_r.st == rivm_pkg::ST_IDLE)
        |=> irq_out && vec_src_o == $past(pick_bus.idx))
        else $error("issued source differs from the pick");

    // fuse is sampled once per reset; a later change waits for the next reset
    a_fuse_held: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (map_r.st != rivm_pkg::ST_SYNC) |=> $stable(map_r.fuse_prog))
        else $error("reset target moved outside the settle window");

    a_select_held: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (irq_out && !vec_ack_i) |=> $stable(map_r.vector_select_bit))
        else $error("vector select changed under an outstanding vector");

    // application table must follow only the select bit, never the fuse
    a_app_table: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (irq_out && !map_r.vector_select_bit) |-> vec_addr_o == rivm_pkg::VEC_TABLE[vec_src_o])
        else $error("application vector moved");

    a_boot_table: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (irq_out && map_r.vector_select_bit) |-> vec_addr_o == BOOT_START + rivm_pkg::VEC_TABLE[vec_src_o])
        else $error("boot vector not offset by the boot start");

    a_src_range: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        irq_out |-> vec_src_o < rivm_pkg::IDX_W'(rivm_pkg::NUM_IRQ))
        else $error("issued source beyond the last vector");

    a_addr_window: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        irq_out |-> rel_addr >= rivm_pkg::VEC_TABLE_BASE
            && rel_addr <= rivm_pkg::VEC_TABLE[rivm_pkg::NUM_IRQ-1])
        else $error("vector outside the interrupt table");

    c_reset_app: cover property (@(posedge mclk_i) disable iff (!nrst_i)
        vec_valid_o && vec_is_reset_o && !map_r.fuse_prog && vec_ack_i);
    c_reset_boot: cover property (@(posedge mclk_i) disable iff (!nrst_i)
        vec_valid_o && vec_is_reset_o && map_r.fuse_prog);
    c_irq_app: cover property (@(posedge mclk_i) disable iff (!nrst_i)
        irq_out && !map_r.vector_select_bit && vec_ack_i);
    c_irq_boot: cover property (@(posedge mclk_i) disable iff (!nrst_i)
        irq_out && map_r.vector_select_bit && vec_ack_i);
    c_two_pending: cover property (@(posedge mclk_i) disable iff (!nrst_i)
        $rose(irq_out) && $countones($past(pending)) > 1);

endmodule : rivm_vector_map

// ==== tb/rivm_core_model.sv ====
// behavioural processor core that accepts presented vectors after a set delay
`timescale 1ns/10ps
module rivm_core_model (
    input  wire logic       mclk_i,
    input  wire logic       nrst_i,
    input  wire logic       vec_valid_i,
    input  wire logic [3:0] delay_i,
    output logic            vec_ack_o
);
    int cnt;

    initial vec_ack_o = 1'b0;

    // ack rises just after an edge and holds until the edge that takes the vector
    always @(posedge mclk_i) begin
        #1;
        if (nrst_i !== 1'b1 || vec_ack_o) begin
            vec_ack_o = 1'b0;
            cnt       = 0;
        end else if (vec_valid_i === 1'b1) begin
            if (cnt >= int'(delay_i)) begin
                vec_ack_o = 1'b1;
            end else begin
                cnt++;
            end
        end
    end
endmodule : rivm_core_model

// ==== tb/rivm_vector_map_tb_top.sv ====
// self-checking bench for the reset and interrupt vector map
`timescale 1ns/10ps
module rivm_vector_map_tb_top;
    localparam logic [rivm_pkg::ADDR_W-1:0] BOOT = 12'h800;
    localparam int                          N    = rivm_pkg::NUM_IRQ;

    logic         mclk_i, nrst_i, gie_i, fuse, vector_select_bit, vec_ack, vec_valid, vec_is_reset;
    logic [N-1:0] pend, en, irq_ack;
    logic [11:0]  vec_addr;
    logic [4:0]   vec_src;
    logic [3:0]   delay;
    logic [15:0]  lfsr_s;
    bit           exp_reset;
    int           mismatches, n_compared;

    rivm_vector_map #(.BOOT_START(BOOT)) uut (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .irq_req_i(pend), .irq_en_i(en), .gie_i(gie_i),
        .boot_reset_fuse_i(fuse), .vector_select_bit_i(vector_select_bit), .vec_ack_i(vec_ack),
        .vec_valid_o(vec_valid), .vec_addr_o(vec_addr), .vec_is_reset_o(vec_is_reset),
        .vec_src_o(vec_src), .irq_ack_o(irq_ack)
    );

    rivm_core_model core (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .vec_valid_i(vec_valid), .delay_i(delay),
        .vec_ack_o(vec_ack)
    );

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    task automatic report_and_stop();
        if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] seen);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk_val

    task automatic chk_vec(input logic [11:0] ea, input logic [4:0] es, input logic er);
        chk_val("vec_addr", 32'(ea), 32'(vec_addr));
        chk_val("vec_src", 32'(es), 32'(vec_src));
        chk_val("vec_is_reset", 32'(er), 32'(vec_is_reset));
    endtask : chk_vec

    function automatic logic [15:0] nxt(input logic [15:0] s);
        logic [15:0] v;
        v = s;
        for (int i = 0; i < 16; i++) v = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
        return v;
    endfunction : nxt

    function automatic int lowest(input logic [N-1:0] m);
        for (int i = 0; i < N; i++) if (m[i]) return i;
        return -1;
    endfunction : lowest

    // model of the core side: each taken vector must be the lowest enabled pending one
    always @(posedge mclk_i) begin : mon
        int          idx;
        logic [11:0] ea;
        if (nrst_i === 1'b1 && vec_valid === 1'b1 && vec_ack === 1'b1) begin
            if (exp_reset) begin
                chk_vec(fuse ? 12'h000 : BOOT, 5'h00, 1'b1);
                chk_val("irq_ack", 32'h0000_0000, 32'(irq_ack));
                exp_reset = 1'b0;
            end else begin
                idx = lowest(pend & en);
                ea  = (vector_select_bit ? BOOT : 12'h000) + 12'(idx + 1);
                chk_val("vector for pending", 32'h0000_0001, 32'(idx >= 0));
                chk_vec(ea, idx[4:0], 1'b0);
                chk_val("irq_ack", 32'(N'(1) << idx), 32'(irq_ack));
            end
        end
    end

    // peripherals drop their flag once acknowledged
    always @(posedge mclk_i) begin : flags
        logic [N-1:0] a;
        a = irq_ack;
        if (a !== '0) begin
            #1;
            pend = pend & ~a;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : tick

    task automatic do_reset(input logic f);
        int k;
        k      = 0;
        nrst_i = 1'b0;
        fuse   = f;
        tick(5);
        exp_reset = 1'b1;
        nrst_i    = 1'b1;
        while (exp_reset && k < 40) begin
            tick(1);
            k++;
        end
        chk_val("reset vector taken", 32'h0000_0000, 32'(exp_reset));
    endtask : do_reset

    task automatic drain();
        int k;
        k = 0;
        while ((pend & en) !== '0 && k < 400) begin
            tick(1);
            k++;
        end
        chk_val("drain done", 32'h0000_0000, 32'(k == 400));
        tick(3);
    endtask : drain

    initial begin
        nrst_i     = 1'b0;
        gie_i      = 1'b1;
        fuse       = 1'b1;
        vector_select_bit      = 1'b0;
        pend       = '0;
        en         = '1;
        delay      = 4'h0;
        lfsr_s     = 16'h001E;
        exp_reset  = 1'b0;
        mismatches = 0;
        n_compared = 0;
        #1;
        // every fuse and select pairing, every source alone
        for (int c = 0; c < 4; c++) begin
            vector_select_bit = c[0];
            do_reset(c[1]);
            delay = 4'(c);
            for (int i = 0; i < N; i++) begin
                pend[i] = 1'b1;
                drain();
            end
        end
        // random batches of simultaneous requests, some disabled
        for (int b = 0; b < 40; b++) begin
            lfsr_s = nxt(lfsr_s);
            vector_select_bit  = lfsr_s[0];
            delay  = {2'b00, lfsr_s[2:1]};
            en     = {lfsr_s[8:0], lfsr_s};
            lfsr_s = nxt(lfsr_s);
            en[15:0] = en[15:0] | lfsr_s;
            lfsr_s = nxt(lfsr_s);
            pend   = {lfsr_s[12:4], nxt(lfsr_s)};
            drain();
            pend = '0;
            tick(1);
        end
        // nothing is fetched while interrupts are off globally or per source
        gie_i = 1'b0;
        pend  = '1;
        tick(20);
        chk_val("vec_valid gie low", 32'h0000_0000, 32'(vec_valid));
        gie_i = 1'b1;
        drain();
        en   = '0;
        pend = '1;
        tick(10);
        chk_val("vec_valid disabled", 32'h0000_0000, 32'(vec_valid));
        en = '1;
        // requests left pending through reset must wait behind the reset vector
        do_reset(1'b0);
        drain();
        report_and_stop();
    end

    initial begin
        #(250_000);
        mismatches++;
        $display("[ERR] watchdog expected done seen hang");
        report_and_stop();
    end
endmodule : rivm_vector_map_tb_top
